// ===== inc/bml_pkg.sv
// Package of constants and types for the boot-mode ROM loader
package bml_pkg;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 32;
    // ---------------------------------------------------------------
    // Address map
    // ---------------------------------------------------------------
    localparam logic [23:0] ROM_BASE = 24'h000000;
    localparam logic [23:0] ROM_LAST = 24'h000FFF;
    localparam logic [23:0] SRC_IRQ0_ADDR = 24'h001000;
    localparam logic [23:0] SRC_IRQ1_ADDR = 24'h400000;
    localparam logic [23:0] SRC_IRQ2_ADDR = 24'hFFF000;
    localparam logic [23:0] SRAM_VECTOR_BASE = 24'h809FC1;
    localparam logic [23:0] BOOT_STACK_LO = 24'h809800;
    localparam logic [23:0] BOOT_STACK_HI = 24'h809801;
    // ---------------------------------------------------------------
    // Vector table and sources
    // ---------------------------------------------------------------
    localparam int VEC_COUNT = 64;
    localparam logic [11:0] VEC_LAST = 12'h03F;
    localparam logic [11:0] VEC_RESET_IDX = 12'h000;
    localparam logic [1:0] SERIAL_WORD_BYTES = 2'h3;
    typedef enum logic [4:0] {
        SRC_NONE = 5'b00001,
        SRC_MEM0 = 5'b00010,
        SRC_MEM1 = 5'b00100,
        SRC_MEM2 = 5'b01000,
        SRC_SER = 5'b10000
    } bml_source_type;
    typedef enum logic [3:0] {
        ST_RESET = 4'b0001,
        ST_POLL = 4'b0010,
        ST_LOAD = 4'b0100,
        ST_DONE = 4'b1000
    } bml_state_type;
endpackage : bml_pkg

// ===== core/bml_boot_loader.sv
// Boot-mode decode, boot source select and loader control
//
// Functional notes
// - Boot select high maps ROM at lowest 4K words; reset starts there.
// - In boot mode no external bus activity until a source is chosen.
// - Irq zero, one, two select reads from three fixed external addresses.
// - Irq three selects serial boot: 32-bit words, external clock, frame.
// - Vectors are fixed ROM values pointing into SRAM from the base.
// - Two SRAM stack words are used by the loader; never load there.
// - Flag pin zero floats after reset; code may drive it low.
// - Single repeat executes one fetched opcode several times.
// - After reset edge detection is off; low inputs seen as levels.
`timescale 1ns/1ps
module bml_boot_loader (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Mode and interrupt pins
    input wire logic boot_mode_select_i,
    input wire logic ext_irq_zero_i,
    input wire logic ext_irq_one_i,
    input wire logic ext_irq_two_i,
    input wire logic ext_irq_three_i,
    input wire logic edge_trigger_select_i,
    // CPU fetch and load side
    input wire logic [bml_pkg::ADDR_W-1:0] cpu_addr_i,
    input wire logic cpu_access_i,
    input wire logic cpu_ext_busy_i,
    input wire logic load_valid_i,
    input wire logic [bml_pkg::ADDR_W-1:0] load_addr_i,
    input wire logic boot_done_i,
    // Flag pin control from code
    input wire logic flag_drive_low_i,
    // Repeat single
    input wire logic repeat_start_i,
    input wire logic [7:0] repeat_count_i,
    input wire logic [bml_pkg::DATA_W-1:0] fetch_opcode_i,
    // Outputs
    output logic rom_select_o,
    output logic ext_bus_select_o,
    output logic [bml_pkg::ADDR_W-1:0] rom_vector_o,
    output logic [4:0] boot_source_o,
    output logic [bml_pkg::ADDR_W-1:0] boot_src_addr_o,
    output logic serial_boot_o,
    output logic load_allowed_o,
    output logic stack_clash_o,
    output logic [3:0] irq_flags_o,
    output logic general_flag_pin_zero_o,
    output logic general_flag_pin_zero_oe_n_o,
    output logic boot_active_o,
    output logic repeat_busy_o,
    output logic [bml_pkg::DATA_W-1:0] exec_opcode_o
);
    import bml_pkg::*;

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    bml_state_type state_q;
    bml_source_type src_q;
    logic mode_q;
    logic edge_armed_q;
    logic flag_low_q;
    logic [3:0] irq_now;
    logic [3:0] irq_prev_q;
    logic [3:0] irq_flags_q;
    logic [7:0] rep_cnt_q;
    logic [DATA_W-1:0] rep_op_q;
    logic in_rom;
    logic [ADDR_W-1:0] vec_d;

    assign irq_now = {ext_irq_three_i, ext_irq_two_i,
                      ext_irq_one_i, ext_irq_zero_i};

    // ---------------------------------------------------------------
    // Boot mode and flag pin
    // ---------------------------------------------------------------
    // Flag pin floats
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            flag_low_q <= 1'b0;
        end else begin
            flag_low_q <= flag_drive_low_i;
        end
    end

    // Mode only follows the pin while no external access is underway.
    // Guarded mode change
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            mode_q <= 1'b1;
        end else if (!cpu_ext_busy_i) begin
            mode_q <= boot_mode_select_i;
        end
    end

    // ---------------------------------------------------------------
    // Interrupt detection
    // ---------------------------------------------------------------
    // Edge off after reset
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            edge_armed_q <= 1'b0;
        end else if (state_q == ST_DONE) begin
            edge_armed_q <= 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            irq_prev_q <= 4'hF;
            irq_flags_q <= 4'h0;
        end else begin
            irq_prev_q <= irq_now;
            if (edge_armed_q && edge_trigger_select_i) begin
                irq_flags_q <= irq_prev_q & ~irq_now;
            end else begin
                irq_flags_q <= ~irq_now;
            end
        end
    end

    // ---------------------------------------------------------------
    // Boot source selection
    // ---------------------------------------------------------------
    // Poll low inputs
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            state_q <= ST_RESET;
            src_q <= SRC_NONE;
        end else begin
            case (state_q)
                ST_RESET: begin
                    state_q <= mode_q ? ST_POLL : ST_DONE;
                end
                ST_POLL: begin
                    if (irq_flags_q[0]) begin
                        src_q <= SRC_MEM0;
                        state_q <= ST_LOAD;
                    end else if (irq_flags_q[1]) begin
                        src_q <= SRC_MEM1;
                        state_q <= ST_LOAD;
                    end else if (irq_flags_q[2]) begin
                        src_q <= SRC_MEM2;
                        state_q <= ST_LOAD;
                    end else if (irq_flags_q[3]) begin
                        src_q <= SRC_SER;
                        state_q <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    if (boot_done_i) begin
                        state_q <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    state_q <= ST_DONE;
                end
                default: begin
                    state_q <= ST_RESET;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Address decode and vectors
    // ---------------------------------------------------------------
    assign in_rom = (cpu_addr_i <= ROM_LAST);

    always_comb begin
        vec_d = ROM_BASE;
        if (cpu_addr_i[11:0] <= VEC_LAST) begin
            vec_d = SRAM_VECTOR_BASE + {12'h000, cpu_addr_i[11:0]};
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            rom_vector_o <= SRAM_VECTOR_BASE;
        end else begin
            rom_vector_o <= vec_d;
        end
    end

    assign rom_select_o = mode_q && cpu_access_i && in_rom;
    assign ext_bus_select_o = cpu_access_i && !(mode_q && in_rom)
        && !(mode_q && (state_q == ST_POLL || state_q == ST_RESET));

    always_comb begin
        case (src_q)
            SRC_MEM0: boot_src_addr_o = SRC_IRQ0_ADDR;
            SRC_MEM1: boot_src_addr_o = SRC_IRQ1_ADDR;
            SRC_MEM2: boot_src_addr_o = SRC_IRQ2_ADDR;
            default: boot_src_addr_o = ROM_BASE;
        endcase
    end

    assign stack_clash_o = load_valid_i && (state_q == ST_LOAD) &&
        (load_addr_i == BOOT_STACK_LO || load_addr_i == BOOT_STACK_HI);
    assign load_allowed_o = load_valid_i && (state_q == ST_LOAD) &&
        !stack_clash_o;

    // ---------------------------------------------------------------
    // Single-instruction repeat
    // ---------------------------------------------------------------
    // One fetch feeds every pass, so a mode switch mid-repeat is safe.
    // Repeat from one fetch
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            rep_cnt_q <= 8'h00;
            rep_op_q <= 32'h00000000;
        end else if (repeat_start_i && rep_cnt_q == 8'h00) begin
            rep_cnt_q <= repeat_count_i;
            rep_op_q <= fetch_opcode_i;
        end else if (rep_cnt_q != 8'h00) begin
            rep_cnt_q <= rep_cnt_q - 8'h01;
        end
    end

    assign repeat_busy_o = (rep_cnt_q != 8'h00);
    assign exec_opcode_o = rep_op_q;
    assign boot_source_o = src_q;
    assign serial_boot_o = (src_q == SRC_SER);
    assign irq_flags_o = irq_flags_q;
    assign boot_active_o = mode_q;
    assign general_flag_pin_zero_o = 1'b0;
    assign general_flag_pin_zero_oe_n_o = !flag_low_q;
endmodule : bml_boot_loader

// ===== verification/bml_boot_loader_sva.sv
// Port checker for the boot loader
`timescale 1ns/1ps
module bml_boot_loader_sva (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Mode and interrupt pins
    input wire logic boot_mode_select_i,
    input wire logic ext_irq_zero_i,
    // CPU side
    input wire logic [bml_pkg::ADDR_W-1:0] cpu_addr_i,
    input wire logic [bml_pkg::ADDR_W-1:0] load_addr_i,
    input wire logic cpu_access_i,
    input wire logic cpu_ext_busy_i,
    input wire logic repeat_start_i,
    input wire logic [7:0] repeat_count_i,
    // Observed outputs
    input wire logic rom_select_o,
    input wire logic ext_bus_select_o,
    input wire logic serial_boot_o,
    input wire logic [bml_pkg::ADDR_W-1:0] rom_vector_o,
    input wire logic [bml_pkg::ADDR_W-1:0] boot_src_addr_o,
    input wire logic [4:0] boot_source_o,
    input wire logic [3:0] irq_flags_o,
    input wire logic load_allowed_o,
    input wire logic general_flag_pin_zero_o,
    input wire logic general_flag_pin_zero_oe_n_o,
    input wire logic boot_active_o,
    input wire logic repeat_busy_o
);
    import bml_pkg::*;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    AST_ROM_MAP: assert property (boot_mode_select_i && boot_active_o
        && cpu_access_i && cpu_addr_i <= ROM_LAST |-> rom_select_o)
        else $error("boot range missed the ROM");
    AST_NO_EXT: assert property (boot_active_o
        && boot_source_o == SRC_NONE |-> !ext_bus_select_o)
        else $error("bus used before a source was chosen");
    AST_SRC_ADDR: assert property (boot_source_o == SRC_MEM2
        |-> boot_src_addr_o == SRC_IRQ2_ADDR)
        else $error("wrong source address");
    AST_SERIAL: assert property (
        serial_boot_o == (boot_source_o == SRC_SER))
        else $error("serial flag disagrees with source");
    AST_VECTOR: assert property (!$past(rst_i) && $past(rom_select_o)
        && $past(cpu_addr_i[11:0]) <= VEC_LAST |->
        rom_vector_o == SRAM_VECTOR_BASE + $past(cpu_addr_i[11:0]))
        else $error("vector does not point into SRAM");
    AST_STACK: assert property (load_allowed_o |->
        load_addr_i != BOOT_STACK_LO && load_addr_i != BOOT_STACK_HI)
        else $error("load allowed into the loader stack");
    AST_MODE_HOLD: assert property (cpu_ext_busy_i |=>
        $stable(boot_active_o))
        else $error("mode changed during external access");
    AST_FLAG_FLOAT: assert property ($fell(rst_i) |->
        general_flag_pin_zero_oe_n_o && !general_flag_pin_zero_o)
        else $error("flag pin driven after reset");
    AST_REPEAT: assert property (repeat_start_i && !repeat_busy_o
        && repeat_count_i == 8'h02 |=> repeat_busy_o ##1 repeat_busy_o
        ##1 !repeat_busy_o)
        else $error("repeat length wrong");
    AST_LEVEL: assert property (boot_source_o == SRC_NONE
        && !ext_irq_zero_i |=> irq_flags_o[0])
        else $error("low pin not seen as level");
    AST_MP_MODE: assert property (!boot_mode_select_i
        && !boot_active_o && cpu_access_i |->
        !rom_select_o && ext_bus_select_o)
        else $error("low range not sent to the bus");
endmodule : bml_boot_loader_sva
bind bml_boot_loader bml_boot_loader_sva chk_i (.*);

// ===== verification/bml_boot_host.sv
// Boot host model: selection pins and mode pull-up
`timescale 1ns/1ps
module bml_boot_host (
    // Clock and selection
    input wire logic clock_i,
    input wire logic [2:0] pick_i,
    // Flag pin from device
    input wire logic flag_i,
    input wire logic flag_oe_n_i,
    // Pins to device
    output logic [3:0] irq_n_o,
    output logic mode_o
);
    always_ff @(posedge clock_i) begin
        irq_n_o <= 4'hF;
        if (pick_i != 3'h0) begin
            irq_n_o[pick_i - 3'h1] <= 1'b0;
        end
    end
    assign mode_o = flag_oe_n_i ? 1'b1 : flag_i;
endmodule : bml_boot_host

// ===== verification/bml_boot_loader_bench.sv
// Testbench for the boot loader
`timescale 1ns/1ps
module bml_boot_loader_bench;
    import bml_pkg::*;
    logic clock_i = 1'b0, rst_i = 1'b1, cpu_access_i = 1'b0;
    logic cpu_ext_busy_i = 1'b0, load_valid_i = 1'b0, boot_done_i = 1'b0;
    logic flag_drive_low_i = 1'b0, repeat_start_i = 1'b0;
    logic edge_trigger_select_i = 1'b0;
    logic [23:0] cpu_addr_i = 24'h000000, load_addr_i = 24'h000000;
    logic [7:0] repeat_count_i = 8'h00;
    logic [31:0] fetch_opcode_i = 32'hA5C30F96;
    logic [2:0] pick = 3'h0;
    logic boot_mode_select_i, ext_irq_zero_i, ext_irq_one_i, ext_irq_two_i;
    logic ext_irq_three_i, rom_select_o, ext_bus_select_o, serial_boot_o;
    logic load_allowed_o, stack_clash_o, general_flag_pin_zero_o;
    logic general_flag_pin_zero_oe_n_o, boot_active_o, repeat_busy_o;
    logic [23:0] rom_vector_o, boot_src_addr_o;
    logic [4:0] boot_source_o;
    logic [3:0] irq_flags_o;
    logic [31:0] exec_opcode_o;
    int err_count = 0;
    int checks = 0;
    bml_boot_loader uut (.*);
    bml_boot_host host (.clock_i(clock_i), .pick_i(pick),
        .flag_i(general_flag_pin_zero_o),
        .flag_oe_n_i(general_flag_pin_zero_oe_n_o),
        .irq_n_o({ext_irq_three_i, ext_irq_two_i, ext_irq_one_i,
        ext_irq_zero_i}), .mode_o(boot_mode_select_i));
    always #2.5 clock_i = ~clock_i;
    task chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task summarize;
        if (err_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize
    task t_source(input logic [2:0] p, input logic [4:0] es,
            input logic [23:0] ea);
        @(posedge clock_i);
        rst_i <= 1'b1;
        pick <= 3'h0;
        // Edge mode asked for, yet boot must still see levels
        edge_trigger_select_i <= 1'b1;
        cpu_access_i <= 1'b1;
        cpu_addr_i <= SRC_IRQ1_ADDR;
        repeat (16) @(posedge clock_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        #1;
        chk({ext_bus_select_o, general_flag_pin_zero_oe_n_o}, 2'b01);
        @(posedge clock_i);
        pick <= p;
        repeat (4) @(posedge clock_i);
        #1;
        chk({boot_source_o, boot_src_addr_o}, {es, ea});
        chk({serial_boot_o, irq_flags_o}, {p[2], 4'h1 << (p - 3'h1)});
    endtask : t_source
    task t_rom;
        @(posedge clock_i);
        cpu_addr_i <= 24'h000005;
        @(posedge clock_i);
        cpu_addr_i <= ROM_LAST;
        #1;
        // Vector lands on a branch slot in SRAM
        chk(rom_vector_o, SRAM_VECTOR_BASE + 24'h5);
        chk(rom_select_o, 1'b1);
        @(posedge clock_i);
        cpu_addr_i <= SRC_IRQ0_ADDR;
        #1;
        chk({rom_vector_o, rom_select_o}, 25'h0);
    endtask : t_rom
    task t_stack;
        @(posedge clock_i);
        load_valid_i <= 1'b1;
        load_addr_i <= BOOT_STACK_HI;
        #1;
        chk({load_allowed_o, stack_clash_o}, 2'b01);
        @(posedge clock_i);
        load_addr_i <= BOOT_STACK_HI + 24'h1;
        #1;
        chk({load_allowed_o, stack_clash_o}, 2'b10);
        @(posedge clock_i);
        load_valid_i <= 1'b0;
        boot_done_i <= 1'b1;
        @(posedge clock_i);
        boot_done_i <= 1'b0;
        // Loaded program reuses the stack words
        load_valid_i <= 1'b1;
        load_addr_i <= BOOT_STACK_LO;
        #1;
        chk({load_allowed_o, stack_clash_o}, 2'b00);
        @(posedge clock_i);
        load_valid_i <= 1'b0;
    endtask : t_stack
    task t_mode;
        @(posedge clock_i);
        cpu_ext_busy_i <= 1'b1;
        flag_drive_low_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        #1;
        chk({general_flag_pin_zero_oe_n_o, general_flag_pin_zero_o,
            boot_active_o}, 3'b001);
        // Edge mode armed after boot: a held-low pin raises nothing
        chk(irq_flags_o, 4'h0);
        @(posedge clock_i);
        // Internal code leaves boot with no repeat
        cpu_ext_busy_i <= 1'b0;
        cpu_addr_i <= ROM_BASE;
        repeat (3) @(posedge clock_i);
        #1;
        chk({boot_active_o, rom_select_o, ext_bus_select_o}, 3'b001);
    endtask : t_mode
    task t_repeat;
        @(posedge clock_i);
        repeat_start_i <= 1'b1;
        repeat_count_i <= 8'h02;
        @(posedge clock_i);
        repeat_start_i <= 1'b0;
        #1;
        chk(repeat_busy_o, 1'b1);
        @(posedge clock_i);
        #1;
        chk(repeat_busy_o, 1'b1);
        @(posedge clock_i);
        #1;
        chk({repeat_busy_o, exec_opcode_o}, {1'b0, fetch_opcode_i});
    endtask : t_repeat
    initial begin
        #20000;
        err_count++;
        summarize();
    end
    initial begin
        t_source(3'h1, SRC_MEM0, SRC_IRQ0_ADDR);
        t_source(3'h2, SRC_MEM1, SRC_IRQ1_ADDR);
        t_source(3'h3, SRC_MEM2, SRC_IRQ2_ADDR);
        t_source(3'h4, SRC_SER, 24'h000000);
        t_rom();
        t_stack();
        t_mode();
        t_repeat();
        summarize();
    end
endmodule : bml_boot_loader_bench
